// ==== sfr_space_dual_data_pointer.sv ====
`include "sfr_defines.svh"
module sfr_space_dual_data_pointer #(
  parameter int MULDIV_CYCLES = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sfr_pkg::sfr_req_t req_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  input wire sfr_pkg::ptr_op_t ptr_op_i,
  input wire logic [15:0] ptr_load_i,
  input wire sfr_pkg::instr_req_t instr_i,
  output logic instr_busy_o,
  output logic instr_done_o,
  output logic cycle_strobe_o,
  output logic [15:0] active_data_pointer_o,
  output logic pointer_select_o,
  output logic [2:0] timer_tick_o
);
  import sfr_pkg::*;

  // Refuse a multiply or divide length that the one-to-five bound cannot hold
  if (MULDIV_CYCLES < `MIN_INSTR_CYCLES || MULDIV_CYCLES > `MAX_INSTR_CYCLES) begin
    $error("MULDIV_CYCLES out of range");
  end

  logic [7:0] port0_latch_q, stack_pointer_reg_q, pointer_a_low_q, pointer_a_high_q;
  logic [7:0] pointer_b_low_q, pointer_b_high_q, pointer_select_reg_q, power_control_reg_q;
  logic [7:0] timer_control_reg_q, timer_mode_reg_q, timer_zero_low_q, timer_one_low_q;
  logic [7:0] timer_zero_high_q, timer_one_high_q, clock_rate_reg_q, special_function_ctl_q;
  logic [7:0] port1_latch_q, extra_irq_flags_q, memory_page_reg_q;
  logic [7:0] port0_drive_strength_q, port0_direction_q;
  logic [7:0] rdata_d;
  logic [15:0] primary_data_pointer, secondary_data_pointer, ptr_next;
  logic sel;
  logic [1:0] phase_q;
  logic [2:0] cycles_left_q;
  logic busy_q;
  logic [3:0] prescale_q;
  logic [2:0] cycles_needed;

  function automatic logic wr_to(input sfr_req_t r, input logic [7:0] a);
    wr_to = r.wr && (r.addr == a);
  endfunction

  function automatic logic [7:0] fixed_bits(input logic [7:0] v, input logic [7:0] m,
                                            input logic [7:0] f);
    fixed_bits = (v & ~m) | (f & m);
  endfunction

  assign sel = pointer_select_reg_q[`SEL_BIT];
  assign primary_data_pointer = {pointer_a_high_q, pointer_a_low_q};
  assign secondary_data_pointer = {pointer_b_high_q, pointer_b_low_q};
  assign ptr_next = (ptr_op_i == OP_LOAD_POINTER) ? ptr_load_i
                  : (sel ? secondary_data_pointer : primary_data_pointer) + 16'h0001;

  // Pointer bytes: bus writes, then pointer instructions on the selected pair
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pointer_a_low_q <= `RST_ZERO;
      pointer_a_high_q <= `RST_ZERO;
      pointer_b_low_q <= `RST_ZERO;
      pointer_b_high_q <= `RST_ZERO;
    end else begin
      if (wr_to(req_i, `ADDR_POINTER_A_LOW)) pointer_a_low_q <= req_i.wdata;
      if (wr_to(req_i, `ADDR_POINTER_A_HIGH)) pointer_a_high_q <= req_i.wdata;
      if (wr_to(req_i, `ADDR_POINTER_B_LOW)) pointer_b_low_q <= req_i.wdata;
      if (wr_to(req_i, `ADDR_POINTER_B_HIGH)) pointer_b_high_q <= req_i.wdata;
      if (ptr_op_i == OP_LOAD_POINTER || ptr_op_i == OP_INC_POINTER) begin
        if (sel) begin
          {pointer_b_high_q, pointer_b_low_q} <= ptr_next;
        end else begin
          {pointer_a_high_q, pointer_a_low_q} <= ptr_next;
        end
      end
    end
  end

  // Select register keeps only bit 0; upper bits read as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pointer_select_reg_q <= `RST_ZERO;
    end else if (ptr_op_i == OP_INC_SELECT) begin
      pointer_select_reg_q <= {7'h00, ~sel};
    end else if (wr_to(req_i, `ADDR_POINTER_SELECT)) begin
      pointer_select_reg_q <= {7'h00, req_i.wdata[`SEL_BIT]};
    end
  end

  // General storage registers; unassigned bits are kept but unused, except special function bits 7:1 (cleared) and the forced power and flag bits
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port0_latch_q <= `RST_PORT_LATCH;
      stack_pointer_reg_q <= `RST_STACK_POINTER;
      power_control_reg_q <= `POWER_FIXED_VAL;
      timer_control_reg_q <= `RST_ZERO;
      timer_mode_reg_q <= `RST_ZERO;
      timer_zero_low_q <= `RST_ZERO;
      timer_one_low_q <= `RST_ZERO;
      timer_zero_high_q <= `RST_ZERO;
      timer_one_high_q <= `RST_ZERO;
      clock_rate_reg_q <= `RST_CLOCK_RATE;
      special_function_ctl_q <= `RST_ZERO;
      port1_latch_q <= `RST_PORT_LATCH;
      extra_irq_flags_q <= `RST_EXTRA_IRQ;
      memory_page_reg_q <= `RST_ZERO;
      port0_drive_strength_q <= `RST_ZERO;
      port0_direction_q <= `RST_PORT_LATCH;
    end else if (req_i.wr) begin
      if (req_i.addr == `ADDR_PORT0_LATCH) port0_latch_q <= req_i.wdata;
      else if (req_i.addr == `ADDR_STACK_POINTER) stack_pointer_reg_q <= req_i.wdata;
      else if (req_i.addr == `ADDR_POWER_CONTROL) begin
        power_control_reg_q <= fixed_bits(req_i.wdata, `POWER_FIXED_MASK,
                                          `POWER_FIXED_VAL);
      end
      else if (req_i.addr == `ADDR_TIMER_CONTROL) timer_control_reg_q <= req_i.wdata;
      else if (req_i.addr == `ADDR_TIMER_MODE) timer_mode_reg_q <= req_i.wdata;
      else if (req_i.addr == `ADDR_TIMER_ZERO_LOW) timer_zero_low_q <= req_i.wdata;
      else if (req_i.addr == `ADDR_TIMER_ONE_LOW) timer_one_low_q <= req_i.wdata;
      else if (req_i.addr == `ADDR_TIMER_ZERO_HIGH) timer_zero_high_q <= req_i.wdata;
      else if (req_i.addr == `ADDR_TIMER_ONE_HIGH) timer_one_high_q <= req_i.wdata;
      else if (req_i.addr == `ADDR_CLOCK_RATE) clock_rate_reg_q <= req_i.wdata;
      else if (req_i.addr == `ADDR_SPECIAL_FUNCTION) begin
        special_function_ctl_q <= {7'h00, req_i.wdata[0]};
      end
      else if (req_i.addr == `ADDR_PORT1_LATCH) port1_latch_q <= req_i.wdata;
      else if (req_i.addr == `ADDR_EXTRA_IRQ_FLAGS) begin
        extra_irq_flags_q <= fixed_bits(req_i.wdata, `IRQ_FIXED_MASK,
                                        `IRQ_FIXED_VAL);
      end
      else if (req_i.addr == `ADDR_MEMORY_PAGE) memory_page_reg_q <= req_i.wdata;
      else if (req_i.addr == `ADDR_PORT0_DRIVE) port0_drive_strength_q <= req_i.wdata;
      else if (req_i.addr == `ADDR_PORT0_DIRECTION) port0_direction_q <= req_i.wdata;
      // Pointer and select writes are handled above; other addresses are reserved and writes there are dropped
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    if (req_i.addr == `ADDR_PORT0_LATCH) rdata_d = port0_latch_q;
    else if (req_i.addr == `ADDR_STACK_POINTER) rdata_d = stack_pointer_reg_q;
    else if (req_i.addr == `ADDR_POINTER_A_LOW) rdata_d = pointer_a_low_q;
    else if (req_i.addr == `ADDR_POINTER_A_HIGH) rdata_d = pointer_a_high_q;
    else if (req_i.addr == `ADDR_POINTER_B_LOW) rdata_d = pointer_b_low_q;
    else if (req_i.addr == `ADDR_POINTER_B_HIGH) rdata_d = pointer_b_high_q;
    else if (req_i.addr == `ADDR_POINTER_SELECT) rdata_d = pointer_select_reg_q;
    else if (req_i.addr == `ADDR_POWER_CONTROL) rdata_d = power_control_reg_q;
    else if (req_i.addr == `ADDR_TIMER_CONTROL) rdata_d = timer_control_reg_q;
    else if (req_i.addr == `ADDR_TIMER_MODE) rdata_d = timer_mode_reg_q;
    else if (req_i.addr == `ADDR_TIMER_ZERO_LOW) rdata_d = timer_zero_low_q;
    else if (req_i.addr == `ADDR_TIMER_ONE_LOW) rdata_d = timer_one_low_q;
    else if (req_i.addr == `ADDR_TIMER_ZERO_HIGH) rdata_d = timer_zero_high_q;
    else if (req_i.addr == `ADDR_TIMER_ONE_HIGH) rdata_d = timer_one_high_q;
    else if (req_i.addr == `ADDR_CLOCK_RATE) rdata_d = clock_rate_reg_q;
    else if (req_i.addr == `ADDR_SPECIAL_FUNCTION) rdata_d = special_function_ctl_q;
    else if (req_i.addr == `ADDR_PORT1_LATCH) rdata_d = port1_latch_q;
    else if (req_i.addr == `ADDR_EXTRA_IRQ_FLAGS) rdata_d = extra_irq_flags_q;
    else if (req_i.addr == `ADDR_MEMORY_PAGE) rdata_d = memory_page_reg_q;
    else if (req_i.addr == `ADDR_PORT0_DRIVE) rdata_d = port0_drive_strength_q;
    else if (req_i.addr == `ADDR_PORT0_DIRECTION) rdata_d = port0_direction_q;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
      rvalid_o <= 1'b0;
    end else begin
      rdata_o <= req_i.rd ? rdata_d : rdata_o;
      rvalid_o <= req_i.rd;
    end
  end

  // Cycle count per instruction class, clipped to one..five
  always_comb begin
    cycles_needed = 3'd1;
    case (instr_i.cls)
      CLS_SINGLE: cycles_needed = 3'd1;
      CLS_ACTIVE_DATA_POINTER_READ: cycles_needed = 3'(`ACTIVE_DATA_POINTER_READ_CYCLES);
      CLS_DIRECT_MOVE: cycles_needed = 3'(`DIRECT_MOVE_CYCLES);
      CLS_EXT_MOVE: begin
        if (clock_rate_reg_q[2:0] > 3'd3) cycles_needed = 3'(`MAX_INSTR_CYCLES);
        else cycles_needed = 3'(`EXTERNAL_DATA_MOVE_BASE_CYCLES) + clock_rate_reg_q[2:0];
      end
      CLS_MULDIV: cycles_needed = 3'(MULDIV_CYCLES);
      CLS_BYTES: begin
        if (instr_i.bytes == 3'd0) cycles_needed = 3'd1;
        else if (instr_i.bytes > 3'd5) cycles_needed = 3'(`MAX_INSTR_CYCLES);
        else cycles_needed = instr_i.bytes;
      end
      default: cycles_needed = 3'd1;
    endcase
  end

  // Instruction sequencer: four clocks per instruction cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= 2'd0;
      cycles_left_q <= 3'd0;
      busy_q <= 1'b0;
      instr_done_o <= 1'b0;
      cycle_strobe_o <= 1'b0;
    end else begin
      instr_done_o <= 1'b0;
      cycle_strobe_o <= 1'b0;
      if (!busy_q) begin
        if (instr_i.start) begin
          busy_q <= 1'b1;
          phase_q <= 2'd0;
          cycles_left_q <= cycles_needed;
        end
      end else begin
        phase_q <= phase_q + 2'd1;
        if (phase_q == 2'(`CLOCKS_PER_CYCLE - 1)) begin
          cycle_strobe_o <= 1'b1;
          cycles_left_q <= cycles_left_q - 3'd1;
          if (cycles_left_q == 3'd1) begin
            busy_q <= 1'b0;
            instr_done_o <= 1'b1;
          end
        end
      end
    end
  end
  assign instr_busy_o = busy_q;

  // Timer ticks: twelve-clock default, four-clock when the rate bit is set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prescale_q <= 4'd0;
      timer_tick_o <= 3'b000;
    end else begin
      prescale_q <= (prescale_q == 4'(`CLOCKS_PER_SLOW_TICK - 1)) ? 4'd0 : prescale_q + 4'd1;
      for (int i = 0; i < 3; i++) begin
        // Fast ticks share the slow prescaler, so a rate change never gives a short gap
        if (clock_rate_reg_q[`CLOCK_RATE_T0_BIT + i]) begin
          timer_tick_o[i] <= (prescale_q[1:0] == 2'(`CLOCKS_PER_FAST_TICK - 1));
        end else begin
          timer_tick_o[i] <= (prescale_q == 4'(`CLOCKS_PER_SLOW_TICK - 1));
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_data_pointer_o <= 16'h0000;
      pointer_select_o <= 1'b0;
    end else begin
      active_data_pointer_o <= sel ? secondary_data_pointer : primary_data_pointer;
      pointer_select_o <= sel;
    end
  end
endmodule

// ==== sfr_defines.svh ====
`ifndef SFR_DEFINES_SVH
`define SFR_DEFINES_SVH
`define ADDR_PORT0_LATCH 8'h80
`define ADDR_STACK_POINTER 8'h81
`define ADDR_POINTER_A_LOW 8'h82
`define ADDR_POINTER_A_HIGH 8'h83
`define ADDR_POINTER_B_LOW 8'h84
`define ADDR_POINTER_B_HIGH 8'h85
`define ADDR_POINTER_SELECT 8'h86
`define ADDR_POWER_CONTROL 8'h87
`define ADDR_TIMER_CONTROL 8'h88
`define ADDR_TIMER_MODE 8'h89
`define ADDR_TIMER_ZERO_LOW 8'h8A
`define ADDR_TIMER_ONE_LOW 8'h8B
`define ADDR_TIMER_ZERO_HIGH 8'h8C
`define ADDR_TIMER_ONE_HIGH 8'h8D
`define ADDR_CLOCK_RATE 8'h8E
`define ADDR_SPECIAL_FUNCTION 8'h8F
`define ADDR_PORT1_LATCH 8'h90
`define ADDR_EXTRA_IRQ_FLAGS 8'h91
`define ADDR_MEMORY_PAGE 8'h92
`define ADDR_PORT0_DRIVE 8'h93
`define ADDR_PORT0_DIRECTION 8'h94
`define RST_STACK_POINTER 8'h07
`define RST_CLOCK_RATE 8'h01
`define RST_EXTRA_IRQ 8'h08
`define RST_PORT_LATCH 8'hFF
`define RST_ZERO 8'h00
`define SEL_BIT 0
`define CLOCK_RATE_T0_BIT 3
`define CLOCK_RATE_T1_BIT 4
`define CLOCK_RATE_T2_BIT 5
`define POWER_FIXED_MASK 8'h30
`define POWER_FIXED_VAL 8'h30
`define IRQ_FIXED_MASK 8'h0F
`define IRQ_FIXED_VAL 8'h08
`define CLOCKS_PER_CYCLE 4
`define CLOCKS_PER_SLOW_TICK 12
`define CLOCKS_PER_FAST_TICK 4
`define EXTERNAL_DATA_MOVE_BASE_CYCLES 2
`define MIN_INSTR_CYCLES 1
`define MAX_INSTR_CYCLES 5
`define ACTIVE_DATA_POINTER_READ_CYCLES 2
`define DIRECT_MOVE_CYCLES 3
`endif

// ==== sfr_pkg.sv ====
package sfr_pkg;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;
  typedef enum logic [2:0] {
    OP_NONE,
    OP_LOAD_POINTER,
    OP_INC_POINTER,
    OP_INC_SELECT
  } ptr_op_t;
  typedef enum logic [2:0] {
    CLS_SINGLE,
    CLS_ACTIVE_DATA_POINTER_READ,
    CLS_DIRECT_MOVE,
    CLS_EXT_MOVE,
    CLS_MULDIV,
    CLS_BYTES
  } instr_class_t;
  typedef struct packed {
    logic start;
    instr_class_t cls;
    logic [2:0] bytes;
  } instr_req_t;
endpackage

// ==== sfr_checker.sv ====
`include "sfr_defines.svh"
module sfr_checker
  import sfr_pkg::*;
#(
  parameter int MULDIV_CYCLES = 5
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sfr_pkg::sfr_req_t req_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire sfr_pkg::ptr_op_t ptr_op_i,
  input wire logic [15:0] ptr_load_i,
  input wire sfr_pkg::instr_req_t instr_i,
  input wire logic instr_busy_o,
  input wire logic instr_done_o,
  input wire logic cycle_strobe_o,
  input wire logic [15:0] active_data_pointer_o,
  input wire logic pointer_select_o,
  input wire logic [2:0] timer_tick_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [5:0] busy_run_q;
  // Length of the current busy run, never more than five cycles of four clocks
  always_ff @(posedge clk_i) begin
    if (rst_i || !instr_busy_o) begin
      busy_run_q <= 6'h00;
    end else begin
      busy_run_q <= busy_run_q + 6'h01;
    end
  end
  chk_read_answer: assert property (req_i.rd |=> rvalid_o)
    else $error("read not answered");
  chk_select_upper_zero: assert property (rvalid_o && $past(req_i.addr) == `ADDR_POINTER_SELECT
    |-> rdata_o[7:1] == 7'h00) else $error("select upper bits not zero");
  chk_select_toggle: assert property ($past(ptr_op_i) == OP_NONE && !$past(req_i.wr) &&
    ptr_op_i == OP_INC_SELECT && !req_i.wr ##1 ptr_op_i == OP_NONE && !req_i.wr
    |=> pointer_select_o != $past(pointer_select_o, 2)) else $error("select did not toggle");
  chk_load_visible: assert property ((ptr_op_i == OP_LOAD_POINTER && !req_i.wr) ##1
    (ptr_op_i == OP_NONE && !req_i.wr) |=> active_data_pointer_o == $past(ptr_load_i, 2))
    else $error("loaded pointer not shown");
  chk_single_walk: assert property (instr_i.start && !instr_busy_o && instr_i.cls == CLS_SINGLE
    |=> instr_busy_o [*4] ##1 (instr_done_o && !instr_busy_o)) else $error("single cycle walk");
  chk_active_data_pointer_read_time: assert property (instr_i.start && !instr_busy_o &&
    instr_i.cls == CLS_ACTIVE_DATA_POINTER_READ |=> ##8 instr_done_o) else $error("pointer read not 8 clocks");
  chk_direct_move_time: assert property (instr_i.start && !instr_busy_o &&
    instr_i.cls == CLS_DIRECT_MOVE |=> ##12 instr_done_o) else $error("direct move not 12");
  chk_busy_end_done: assert property ($fell(instr_busy_o) |-> instr_done_o)
    else $error("busy fell without done");
  chk_busy_bound: assert property (instr_busy_o |-> busy_run_q < 6'h14)
    else $error("instruction longer than five cycles");
  chk_done_on_strobe: assert property (instr_done_o |-> cycle_strobe_o)
    else $error("done off a cycle boundary");
  chk_strobe_spacing: assert property (cycle_strobe_o |=> !cycle_strobe_o [*3])
    else $error("cycle strobes too close");
  chk_tick_spacing: assert property (timer_tick_o[0] |=> !timer_tick_o[0] [*3])
    else $error("timer ticks too close");
endmodule

bind sfr_space_dual_data_pointer sfr_checker #(.MULDIV_CYCLES(MULDIV_CYCLES)) i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
  .ptr_op_i(ptr_op_i), .ptr_load_i(ptr_load_i), .instr_i(instr_i), .instr_busy_o(instr_busy_o),
  .instr_done_o(instr_done_o), .cycle_strobe_o(cycle_strobe_o), .timer_tick_o(timer_tick_o),
  .active_data_pointer_o(active_data_pointer_o), .pointer_select_o(pointer_select_o));

// ==== tb.sv ====
`include "sfr_defines.svh"
`define CMP(x, y) begin checks++; if ((x) !== (y)) begin n_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, x, y); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sfr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  sfr_req_t req_i = '0;
  ptr_op_t ptr_op_i = OP_NONE;
  logic [15:0] ptr_load_i = 16'h0000;
  instr_req_t instr_i = '0;
  logic [7:0] rdata_o;
  logic rvalid_o, instr_busy_o, instr_done_o, cycle_strobe_o, pointer_select_o;
  logic [15:0] active_data_pointer_o;
  logic [2:0] timer_tick_o;
  int n_errors = 0;
  int checks = 0;
  int seed = 32'h5BE83AFC;
  int mdl [256];
  int n, s, v;
  always #12.5 clk_i = ~clk_i;
  sfr_space_dual_data_pointer #(.MULDIV_CYCLES(4)) i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .ptr_op_i(ptr_op_i), .ptr_load_i(ptr_load_i), .instr_i(instr_i), .instr_busy_o(instr_busy_o),
    .instr_done_o(instr_done_o), .cycle_strobe_o(cycle_strobe_o), .timer_tick_o(timer_tick_o),
    .active_data_pointer_o(active_data_pointer_o), .pointer_select_o(pointer_select_o));
  // Stored value of a register after a write, fixed bits forced
  function automatic int fix(int a, int d);
    case (a)
      8'h86, 8'h8F: return d & 8'h01;
      8'h87: return d | 8'h30;
      8'h91: return (d & 8'hF0) | 8'h08;
      default: return (a >= 8'h80 && a <= 8'h94) ? d & 8'hFF : 0;
    endcase
  endfunction
  function automatic int ptr_of(int sl);
    return (mdl[8'h83 + 2 * sl] << 8) | mdl[8'h82 + 2 * sl];
  endfunction
  task automatic wr(int a, int d);
    @(posedge clk_i);
    req_i <= {1'b1, 1'b0, 8'(a), 8'(d)};
    @(posedge clk_i);
    req_i.wr <= 1'b0;
    mdl[a] = fix(a, d);
  endtask
  task automatic rd(int a);
    @(posedge clk_i);
    req_i <= {1'b0, 1'b1, 8'(a), 8'h00};
    @(posedge clk_i);
    req_i.rd <= 1'b0;
    #1;
    `CMP(rvalid_o, 1'b1)
    `CMP(rdata_o, 8'(mdl[a]))
  endtask
  task automatic op(ptr_op_t o, int ld);
    @(posedge clk_i);
    ptr_op_i <= o;
    ptr_load_i <= 16'(ld);
    @(posedge clk_i);
    ptr_op_i <= OP_NONE;
    s = mdl[8'h86];
    v = (o == OP_LOAD_POINTER) ? ld & 16'hFFFF : ptr_of(s) + 1;
    if (o == OP_INC_SELECT) begin
      mdl[8'h86] = 1 - s;
    end else begin
      mdl[8'h82 + 2 * s] = v & 8'hFF;
      mdl[8'h83 + 2 * s] = (v >> 8) & 8'hFF;
    end
    repeat (2) @(posedge clk_i);
    #1;
    `CMP(pointer_select_o, 1'(mdl[8'h86]))
    `CMP(active_data_pointer_o, 16'(ptr_of(mdl[8'h86])))
  endtask
  task automatic run(instr_class_t c, int b, int exp_n, bit spoil);
    @(posedge clk_i);
    instr_i <= {1'b1, c, 3'(b)};
    @(posedge clk_i);
    instr_i.start <= 1'b0;
    n = 0;
    s = 0;
    #1;
    while (instr_done_o !== 1'b1 && n < 40) begin
      s += (cycle_strobe_o === 1'b1);
      @(posedge clk_i);
      instr_i.start <= spoil && n == 2;
      n++;
      #1;
    end
    s += (cycle_strobe_o === 1'b1);
    `CMP(n, 4 * exp_n)
    `CMP(s, exp_n)
  endtask
  task automatic tick_gap(int t);
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge clk_i);
        #1;
        n++;
      end while (timer_tick_o[t] !== 1'b1 && n < 30);
    end
    `CMP(n, mdl[8'h8E][3 + t] ? 4 : 12)
  endtask
  task automatic results();
    if (n_errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    results();
  end
  initial begin
    for (int a = 0; a < 256; a++) begin
      mdl[a] = fix(a, (a == 8'h80 || a == 8'h90 || a == 8'h94) ? 8'hFF :
        a == 8'h81 ? 8'h07 : a == 8'h8E ? 8'h01 : 0);
    end
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 8'h7F; a <= 8'h95; a++) rd(a);
    for (int a = 8'h80; a <= 8'h94; a++) wr(a, $random(seed));
    for (int a = 8'h7F; a <= 8'h95; a++) rd(a);
    repeat (16) op(ptr_op_t'(1 + $unsigned($random(seed)) % 3), $random(seed));
    op(OP_LOAD_POINTER, 16'hFFFF);
    op(OP_INC_POINTER, 0);
    wr(8'h86, 8'hFF);
    rd(8'h86);
    op(OP_INC_SELECT, 0);
    for (int a = 8'h82; a <= 8'h86; a++) rd(a);
    run(CLS_SINGLE, 0, 1, 0);
    run(CLS_ACTIVE_DATA_POINTER_READ, 0, 2, 1);
    run(CLS_DIRECT_MOVE, 0, 3, 1);
    run(CLS_MULDIV, 0, 4, 0);
    for (int b = 0; b < 8; b++) run(CLS_BYTES, b, b < 1 ? 1 : b > 5 ? 5 : b, 0);
    for (int k = 0; k < 8; k++) begin
      wr(8'h8E, (k << 3) | k);
      run(CLS_EXT_MOVE, 0, k > 3 ? 5 : 2 + k, 1);
      for (int t = 0; t < 3; t++) tick_gap(t);
    end
    results();
  end
endmodule
